//--- design/nvc_pkg.sv
// Constants, encodings and types for the nested vector controller
package nvc_pkg;

   // ==========================================================
   // Exception space
   localparam int          NUM_EXC  = 48;
   localparam int          NUM_IRQ  = 32;
   localparam int          IRQ_BASE = 16;
   localparam logic [47:0] IMPL_MASK = 48'hffff_ffff_d87e;

   localparam logic [5:0] EXC_RESET  = 6'h01;
   localparam logic [5:0] EXC_NMI    = 6'h02;
   localparam logic [5:0] EXC_HARD   = 6'h03;
   localparam logic [5:0] EXC_MEM    = 6'h04;
   localparam logic [5:0] EXC_SVC    = 6'h0b;
   localparam logic [5:0] EXC_DBGMON = 6'h0c;
   localparam logic [5:0] EXC_PENDED_SERVICE_REQUEST = 6'h0e;
   localparam logic [5:0] EXC_TICK   = 6'h0f;
   localparam logic [9:0] VEC_SP     = 10'h000;

   // ==========================================================
   // Priority ranks
   localparam logic [3:0] RANK_PROG = 4'h3;
   localparam logic [3:0] RANK_NONE = 4'hf;

   // ==========================================================
   // Register offsets
   localparam logic [7:0] A_ENABLE  = 8'h00;
   localparam logic [7:0] A_PENDSET = 8'h04;
   localparam logic [7:0] A_PENDCLR = 8'h08;
   localparam logic [7:0] A_ACTIVE  = 8'h0c;
   localparam logic [7:0] A_PRIO_LO = 8'h10;
   localparam logic [7:0] A_PRIO_HI = 8'h3c;
   localparam logic [5:0] PRIO_WORD0 = 6'h04;
   localparam logic [7:0] A_CTRL    = 8'h40;
   localparam logic [7:0] A_SYSSTAT = 8'h44;
   localparam logic [7:0] A_ROUTE   = 8'h48;
   localparam logic [7:0] A_CUR     = 8'h4c;

   // ==========================================================
   // Field positions and reset values
   localparam int C_GRP_LSB  = 0;
   localparam int C_MEM_EN   = 3;
   localparam int C_PENDED_SERVICE_REQUEST   = 6;
   localparam int C_NMI_EN   = 7;
   localparam int C_NMI_LSB  = 8;
   localparam int RT_VEC_LSB = 0;
   localparam int RT_KND_LSB = 8;
   localparam int RT_IDX_LSB = 16;
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [2:0]  PRIO_RST = 3'h0;

   // ==========================================================
   // Timing
   localparam logic [3:0] STACK_CYC = 4'h8;

   // ==========================================================
   // Types
   typedef enum logic [1:0] {
      NVC_KIND_FIXED = 2'h0,
      NVC_KIND_DMA   = 2'h1,
      NVC_KIND_UDB   = 2'h2
   } nvc_kind_t;

   typedef enum logic [3:0] {
      NVC_ST_BOOT  = 4'h1,
      NVC_ST_RUN   = 4'h2,
      NVC_ST_STACK = 4'h4,
      NVC_ST_POP   = 4'h8
   } nvc_state_t;

endpackage

//--- design/nvc_ctrl.sv
// Nested vector controller: exception arbitration, source routing, entry and exit
//
// The implementer's own choices: the register offsets and the strobed register port.
`timescale 1ns/1ps

// Function
// - Sixteen system exceptions, thirty-two peripheral lines
// - Offset zero supplies initial main stack pointer
// - Fixed top priorities; faults escalate to hard
// - Memory manage fault is exception four
// - Bus error raises bus fault five
// - Usage fault is exception six
// - Supervisor call eleven, debug monitor twelve
// - Pended service fourteen, system tick fifteen
// - Peripheral lines map to exceptions 16-47
// - Non-maskable input routed from any pin
// - Eight priority levels, changeable at runtime
// - Grouping splits preempt and sub-priority
// - Tail-chain and late arrival supported
// - Hardware pushes and pops processor state
// - Equal priority: lower vector number first
// - Each vector picks one of three sources
// - Two request lines per DMA channel
// - Any routing array signal can interrupt
// - Any DMA or routing array source routable to any vector; each fixed line reaches only its own vector
module nvc_ctrl #(
   parameter int DMA_CH = 24,
   parameter int UDB_W  = 64,
   parameter int NPIN   = 64
)(
   input  wire logic                  clk_i,
   input  wire logic                  rst_b_i,
   input  wire logic [7:0]            addr_i,
   input  wire logic [31:0]           wdata_i,
   input  wire logic                  wr_i,
   input  wire logic                  rd_i,
   output logic      [31:0]           rdata_o,
   input  wire logic [31:0]           fixed_irq_i,
   input  wire logic [2*DMA_CH-1:0]   dma_irq_i,
   input  wire logic [UDB_W-1:0]      udb_sig_i,
   input  wire logic [NPIN-1:0]       pins_i,
   input  wire logic                  mem_fault_i,
   input  wire logic                  bus_fault_i,
   input  wire logic                  usage_fault_i,
   input  wire logic                  svc_i,
   input  wire logic                  dbg_mon_i,
   input  wire logic                  system_tick_exception_i,
   input  wire logic                  exc_ret_i,
   output logic                       exc_take_o,
   output logic      [5:0]            exc_num_o,
   output logic      [9:0]            vec_addr_o,
   output logic                       sp_load_o,
   output logic                       stack_push_o,
   output logic                       stack_pop_o,
   output logic                       tail_chain_o
);

   // ==========================================================
   // Priority helpers
   function automatic logic [3:0] f_full(input logic [5:0] n, input logic [2:0] p);
      if (n < nvc_pkg::EXC_MEM)
         return 4'(n - 6'h01);
      return nvc_pkg::RANK_PROG + {1'b0, p};
   endfunction

   function automatic logic [3:0] f_grp(input logic [5:0] n, input logic [2:0] p,
                                        input logic [1:0] g);
      if (n < nvc_pkg::EXC_MEM)
         return 4'(n - 6'h01);
      return nvc_pkg::RANK_PROG + {1'b0, p >> g};
   endfunction

   // ==========================================================
   // State
   logic [31:0]           en_r, en_nxt;
   logic [31:0]           ctrl_r, ctrl_nxt;
   logic [2:0]            prio_r [nvc_pkg::NUM_EXC];
   logic [2:0]            prio_nxt [nvc_pkg::NUM_EXC];
   nvc_pkg::nvc_kind_t    kind_r [nvc_pkg::NUM_IRQ];
   nvc_pkg::nvc_kind_t    kind_nxt [nvc_pkg::NUM_IRQ];
   logic [5:0]            idx_r [nvc_pkg::NUM_IRQ];
   logic [5:0]            idx_nxt [nvc_pkg::NUM_IRQ];
   logic [4:0]            rt_sel_r, rt_sel_nxt;
   logic [31:0]           rdata_nxt;
   logic [NPIN-1:0]       pin_s1_r, pin_s2_r;
   logic                  nmi_prev_r;
   logic [47:0]           pend_r, pend_nxt;
   logic [47:0]           act_r, act_nxt;
   nvc_pkg::nvc_state_t   st_r, st_nxt;
   logic [3:0]            cnt_r, cnt_nxt;
   logic                  boot_r, boot_nxt;
   logic                  take_nxt, push_nxt, pop_nxt, tail_nxt, sp_nxt;
   logic [5:0]            num_nxt;
   logic [9:0]            vec_nxt;

   logic [31:0]           irq_req;
   logic [1:0]            grp_sh;
   logic [5:0]            prio_word;
   logic                  nmi_lvl, nmi_rise;
   logic [5:0]            cur_num, cand;
   logic                  cur_v, cand_v;
   logic [3:0]            run_grp, run_grp2, cand_grp, cand_full;

   assign grp_sh    = (ctrl_r[nvc_pkg::C_GRP_LSB+:3] > 3'h3) ? 2'h3 :
                      ctrl_r[nvc_pkg::C_GRP_LSB+:2];
   assign prio_word = addr_i[7:2] - nvc_pkg::PRIO_WORD0;

   // ==========================================================
   // Source selection per vector
   genvar v;
   generate
      for (v = 0; v < nvc_pkg::NUM_IRQ; v++) begin : g_src
         assign irq_req[v] =
            (kind_r[v] == nvc_pkg::NVC_KIND_FIXED) ? fixed_irq_i[v] :
            (kind_r[v] == nvc_pkg::NVC_KIND_DMA && int'(idx_r[v]) < 2*DMA_CH) ?
               dma_irq_i[idx_r[v]] :
            (kind_r[v] == nvc_pkg::NVC_KIND_UDB && int'(idx_r[v]) < UDB_W) ?
               udb_sig_i[idx_r[v]] : 1'b0;
      end
   endgenerate

   // ==========================================================
   // Non-maskable input routing
   assign nmi_lvl  = ctrl_r[nvc_pkg::C_NMI_EN] &&
                     int'(ctrl_r[nvc_pkg::C_NMI_LSB+:6]) < NPIN &&
                     pin_s2_r[ctrl_r[nvc_pkg::C_NMI_LSB+:6]];
   assign nmi_rise = nmi_lvl && !nmi_prev_r;

   // ==========================================================
   // Register file next state and read data
   always_comb begin
      en_nxt     = en_r;
      ctrl_nxt   = ctrl_r;
      prio_nxt   = prio_r;
      kind_nxt   = kind_r;
      idx_nxt    = idx_r;
      rt_sel_nxt = rt_sel_r;
      rdata_nxt  = 32'h0000_0000;
      ctrl_nxt[nvc_pkg::C_PENDED_SERVICE_REQUEST] = 1'b0;
      if (wr_i) begin
         if (addr_i == nvc_pkg::A_ENABLE) begin
            en_nxt = wdata_i;
         end else if (addr_i >= nvc_pkg::A_PRIO_LO && addr_i <= nvc_pkg::A_PRIO_HI) begin
            for (int n = 4; n < nvc_pkg::NUM_EXC; n++) begin
               if (nvc_pkg::IMPL_MASK[n] && 6'(n >> 2) == prio_word) begin
                  prio_nxt[n] = wdata_i[8*(n%4)+:3];
               end
            end
         end else if (addr_i == nvc_pkg::A_CTRL) begin
            ctrl_nxt = wdata_i;
         end else if (addr_i == nvc_pkg::A_ROUTE) begin
            rt_sel_nxt = wdata_i[nvc_pkg::RT_VEC_LSB+:5];
            if (wdata_i[nvc_pkg::RT_KND_LSB+:2] <= 2'h2) begin
               kind_nxt[rt_sel_nxt] =
                  nvc_pkg::nvc_kind_t'(wdata_i[nvc_pkg::RT_KND_LSB+:2]);
            end
            idx_nxt[rt_sel_nxt] = wdata_i[nvc_pkg::RT_IDX_LSB+:6];
         end
      end
      if (rd_i) begin
         if (addr_i == nvc_pkg::A_ENABLE) begin
            rdata_nxt = en_r;
         end else if (addr_i == nvc_pkg::A_PENDSET || addr_i == nvc_pkg::A_PENDCLR) begin
            rdata_nxt = pend_r[47:16];
         end else if (addr_i == nvc_pkg::A_ACTIVE) begin
            rdata_nxt = act_r[47:16];
         end else if (addr_i >= nvc_pkg::A_PRIO_LO && addr_i <= nvc_pkg::A_PRIO_HI) begin
            for (int n = 4; n < nvc_pkg::NUM_EXC; n++) begin
               if (nvc_pkg::IMPL_MASK[n] && 6'(n >> 2) == prio_word) begin
                  rdata_nxt[8*(n%4)+:3] = prio_r[n];
               end
            end
         end else if (addr_i == nvc_pkg::A_CTRL) begin
            rdata_nxt = ctrl_r;
         end else if (addr_i == nvc_pkg::A_SYSSTAT) begin
            rdata_nxt = {act_r[15:0], pend_r[15:0]};
         end else if (addr_i == nvc_pkg::A_ROUTE) begin
            rdata_nxt[nvc_pkg::RT_VEC_LSB+:5] = rt_sel_r;
            rdata_nxt[nvc_pkg::RT_KND_LSB+:2] = kind_r[rt_sel_r];
            rdata_nxt[nvc_pkg::RT_IDX_LSB+:6] = idx_r[rt_sel_r];
         end else if (addr_i == nvc_pkg::A_CUR) begin
            rdata_nxt = {18'h0_0000, cand, 2'h0, cur_num};
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         en_r     <= 32'h0000_0000;
         ctrl_r   <= nvc_pkg::CTRL_RST;
         rt_sel_r <= 5'h00;
         rdata_o  <= 32'h0000_0000;
         for (int n = 0; n < nvc_pkg::NUM_EXC; n++) begin
            prio_r[n] <= nvc_pkg::PRIO_RST;
         end
         for (int n = 0; n < nvc_pkg::NUM_IRQ; n++) begin
            kind_r[n] <= nvc_pkg::NVC_KIND_FIXED;
            idx_r[n]  <= 6'h00;
         end
      end else begin
         en_r     <= en_nxt;
         ctrl_r   <= ctrl_nxt;
         rt_sel_r <= rt_sel_nxt;
         rdata_o  <= rdata_nxt;
         prio_r   <= prio_nxt;
         kind_r   <= kind_nxt;
         idx_r    <= idx_nxt;
      end
   end

   // ==========================================================
   // Arbitration
   always_comb begin
      cur_num   = 6'h00;
      cur_v     = 1'b0;
      run_grp   = nvc_pkg::RANK_NONE;
      cand      = 6'h00;
      cand_v    = 1'b0;
      cand_full = nvc_pkg::RANK_NONE;
      for (int n = 1; n < nvc_pkg::NUM_EXC; n++) begin
         if (act_r[n] && f_grp(6'(n), prio_r[n], grp_sh) < run_grp) begin
            run_grp = f_grp(6'(n), prio_r[n], grp_sh);
            cur_num = 6'(n);
            cur_v   = 1'b1;
         end
         if (pend_r[n] && nvc_pkg::IMPL_MASK[n] &&
             (!cand_v || f_full(6'(n), prio_r[n]) < cand_full)) begin
            cand_full = f_full(6'(n), prio_r[n]);
            cand      = 6'(n);
            cand_v    = 1'b1;
         end
      end
      run_grp2 = nvc_pkg::RANK_NONE;
      for (int n = 1; n < nvc_pkg::NUM_EXC; n++) begin
         if (act_r[n] && 6'(n) != cur_num && f_grp(6'(n), prio_r[n], grp_sh) < run_grp2) begin
            run_grp2 = f_grp(6'(n), prio_r[n], grp_sh);
         end
      end
      cand_grp = f_grp(cand, prio_r[cand], grp_sh);
   end

   // ==========================================================
   // Pending, active and entry/exit sequencing
   always_comb begin
      logic [47:0] pset;
      logic [47:0] pclr;
      logic [47:0] aset;
      logic [47:0] aclr;
      logic [2:0]  flt;
      logic [5:0]  fn;
      pset     = '0;
      pclr     = '0;
      aset     = '0;
      aclr     = '0;
      flt      = {usage_fault_i, bus_fault_i, mem_fault_i};
      fn       = 6'h00;
      st_nxt   = st_r;
      cnt_nxt  = cnt_r;
      boot_nxt = boot_r;
      take_nxt = 1'b0;
      push_nxt = 1'b0;
      pop_nxt  = 1'b0;
      tail_nxt = 1'b0;
      sp_nxt   = 1'b0;
      num_nxt  = exc_num_o;
      vec_nxt  = vec_addr_o;
      pset[47:16] = irq_req & en_r;
      if (wr_i && addr_i == nvc_pkg::A_PENDSET) begin
         pset[47:16] = pset[47:16] | wdata_i;
      end
      if (wr_i && addr_i == nvc_pkg::A_PENDCLR) begin
         pclr[47:16] = wdata_i;
      end
      pset[nvc_pkg::EXC_NMI] = nmi_rise;
      for (int k = 0; k < 3; k++) begin
         fn = nvc_pkg::EXC_MEM + 6'(k);
         if (flt[k]) begin
            if (ctrl_r[nvc_pkg::C_MEM_EN+k] && f_grp(fn, prio_r[fn], grp_sh) < run_grp) begin
               pset[fn] = 1'b1;
            end else begin
               pset[nvc_pkg::EXC_HARD] = 1'b1;
            end
         end
      end
      pset[nvc_pkg::EXC_SVC]    = svc_i;
      pset[nvc_pkg::EXC_DBGMON] = dbg_mon_i;
      pset[nvc_pkg::EXC_PENDED_SERVICE_REQUEST] = ctrl_r[nvc_pkg::C_PENDED_SERVICE_REQUEST];
      pset[nvc_pkg::EXC_TICK]   = system_tick_exception_i;
      case (st_r)
         nvc_pkg::NVC_ST_BOOT: begin
            if (!boot_r) begin
               sp_nxt   = 1'b1;
               vec_nxt  = nvc_pkg::VEC_SP;
               boot_nxt = 1'b1;
            end else begin
               take_nxt = 1'b1;
               num_nxt  = nvc_pkg::EXC_RESET;
               vec_nxt  = {2'h0, nvc_pkg::EXC_RESET, 2'h0};
               st_nxt   = nvc_pkg::NVC_ST_RUN;
            end
         end
         nvc_pkg::NVC_ST_RUN: begin
            if (exc_ret_i && cur_v) begin
               aclr[cur_num] = 1'b1;
               if (cand_v && cand_grp < run_grp2) begin
                  take_nxt = 1'b1;
                  tail_nxt = 1'b1;
               end else begin
                  pop_nxt = 1'b1;
                  st_nxt  = nvc_pkg::NVC_ST_POP;
                  cnt_nxt = nvc_pkg::STACK_CYC;
               end
            end else if (cand_v && cand_grp < run_grp) begin
               push_nxt = 1'b1;
               st_nxt   = nvc_pkg::NVC_ST_STACK;
               cnt_nxt  = nvc_pkg::STACK_CYC;
            end
         end
         nvc_pkg::NVC_ST_STACK: begin
            if (cnt_r != 4'h0) begin
               cnt_nxt = cnt_r - 4'h1;
            end else if (cand_v && cand_grp < run_grp) begin
               take_nxt = 1'b1;
               st_nxt   = nvc_pkg::NVC_ST_RUN;
            end else begin
               pop_nxt = 1'b1;
               st_nxt  = nvc_pkg::NVC_ST_POP;
               cnt_nxt = nvc_pkg::STACK_CYC;
            end
         end
         nvc_pkg::NVC_ST_POP: begin
            if (cnt_r != 4'h0) begin
               cnt_nxt = cnt_r - 4'h1;
            end else begin
               st_nxt = nvc_pkg::NVC_ST_RUN;
            end
         end
         default: begin
            st_nxt = nvc_pkg::NVC_ST_BOOT;
         end
      endcase
      if (take_nxt && st_r != nvc_pkg::NVC_ST_BOOT) begin
         aset[cand] = 1'b1;
         pclr[cand] = 1'b1;
         num_nxt    = cand;
         vec_nxt    = {2'h0, cand, 2'h0};
      end
      pend_nxt = (pend_r & ~pclr) | (pset & nvc_pkg::IMPL_MASK);
      act_nxt  = (act_r & ~aclr) | aset;
   end

   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         pin_s1_r     <= '0;
         pin_s2_r     <= '0;
         nmi_prev_r   <= 1'b0;
         pend_r       <= 48'h0000_0000_0000;
         act_r        <= 48'h0000_0000_0000;
         st_r         <= nvc_pkg::NVC_ST_BOOT;
         cnt_r        <= 4'h0;
         boot_r       <= 1'b0;
         exc_take_o   <= 1'b0;
         exc_num_o    <= 6'h00;
         vec_addr_o   <= 10'h000;
         sp_load_o    <= 1'b0;
         stack_push_o <= 1'b0;
         stack_pop_o  <= 1'b0;
         tail_chain_o <= 1'b0;
      end else begin
         pin_s1_r     <= pins_i;
         pin_s2_r     <= pin_s1_r;
         nmi_prev_r   <= nmi_lvl;
         pend_r       <= pend_nxt;
         act_r        <= act_nxt;
         st_r         <= st_nxt;
         cnt_r        <= cnt_nxt;
         boot_r       <= boot_nxt;
         exc_take_o   <= take_nxt;
         exc_num_o    <= num_nxt;
         vec_addr_o   <= vec_nxt;
         sp_load_o    <= sp_nxt;
         stack_push_o <= push_nxt;
         stack_pop_o  <= pop_nxt;
         tail_chain_o <= tail_nxt;
      end
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);

   chk_boot_sp_first: assert property (
      $rose(rst_b_i) |-> ##1 (sp_load_o && vec_addr_o == 10'h000)
                         ##1 (exc_take_o && exc_num_o == 6'h01))
      else $error("boot order wrong");

   chk_no_reserved: assert property (
      exc_take_o |-> nvc_pkg::IMPL_MASK[exc_num_o])
      else $error("reserved exception taken");

   chk_irq_vector: assert property (
      exc_take_o && exc_num_o >= 6'h10 |-> vec_addr_o == {exc_num_o, 2'h0}
                                          && vec_addr_o >= 10'h040)
      else $error("peripheral vector offset wrong");

   chk_push_then_entry: assert property (
      stack_push_o |-> ##[9:10] (exc_take_o || stack_pop_o))
      else $error("stacking did not end in entry");

   chk_tail_no_pop: assert property (
      tail_chain_o |-> exc_take_o && !stack_pop_o && !stack_push_o)
      else $error("tail chain restored state");

   chk_fault_escalate: assert property (
      mem_fault_i && !ctrl_r[nvc_pkg::C_MEM_EN] |=> pend_r[3] || act_r[3])
      else $error("disabled fault not escalated");

   chk_nmi_pend: assert property (
      nmi_rise |=> pend_r[2])
      else $error("routed nmi not pended");

   chk_prio_write: assert property (
      wr_i && addr_i == 8'h20 |=> prio_r[16] == $past(wdata_i[2:0]))
      else $error("priority write lost");

   chk_svc_pend: assert property (
      svc_i |=> pend_r[11] || act_r[11] || $past(take_nxt))
      else $error("supervisor call not pended");

endmodule

//--- testbench/nvc_core_model.sv
// Behavioural processor core that answers exception entries with returns
`timescale 1ns/1ps

module nvc_core_model (
   input  wire logic       clk_i,
   input  wire logic       rst_b_i,
   input  wire logic       exc_take_i,
   input  wire logic       tail_chain_i,
   input  wire logic [5:0] exc_num_i,
   input  wire logic [7:0] delay_i,
   output logic            exc_ret_o,
   output logic [31:0]     handler_o,
   output logic            idle_o
);
   // ==========================================================
   // Handler nesting and return timing
   int   depth;
   int   cnt;
   logic ret_nxt;

   assign idle_o = (depth == 0);

   always @(posedge clk_i) begin
      ret_nxt = 1'b0;
      if (!rst_b_i) begin
         depth = 0;
         cnt   = 0;
         handler_o <= 32'h0000_0000;
      end else begin
         // Reset handler runs as thread; a tail-chained entry follows a return
         if (exc_take_i && (tail_chain_i || exc_num_i != 6'h01)) begin
            depth++;
         end
         if (exc_take_i) begin
            cnt = 0;
            handler_o <= {22'h00_0000, exc_num_i, 4'h1};
         end else if (depth > 0) begin
            cnt++;
         end
         // Return only while a handler is active
         if (depth > 0 && cnt == int'(delay_i) && !exc_ret_o) begin
            ret_nxt = 1'b1;
            depth--;
            cnt = 0;
         end
      end
      exc_ret_o <= ret_nxt;
   end
endmodule

//--- testbench/tb.sv
// Self-checking testbench for the nested vector controller
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_mismatch++; \
   $display("MISMATCH %0t got %0h exp %0h", $time, a, b); end end

module tb;
   logic        clk_i = 1'b0;
   logic        rst_b_i, wr_i, rd_i, exc_ret_i, idle, took, take_tc;
   logic        mem_fault_i, bus_fault_i, usage_fault_i, svc_i, dbg_mon_i, system_tick_exception_i;
   logic        exc_take_o, sp_load_o, stack_push_o, stack_pop_o, tail_chain_o;
   logic [7:0]  addr_i, delay;
   logic [31:0] wdata_i, rdata_o, fixed_irq_i, handler;
   logic [47:0] dma_irq_i;
   logic [63:0] udb_sig_i, pins_i;
   logic [5:0]  exc_num_o, take_num;
   logic [9:0]  vec_addr_o, take_vec, sp_vec;
   int          n_mismatch, checks_done, cyc, push_cyc, take_cyc, sp_cyc, n_pop, j, k;

   always #2 clk_i = ~clk_i;

   nvc_ctrl dut (.clk_i, .rst_b_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .fixed_irq_i,
      .dma_irq_i, .udb_sig_i, .pins_i, .mem_fault_i, .bus_fault_i, .usage_fault_i, .svc_i,
      .dbg_mon_i, .system_tick_exception_i, .exc_ret_i, .exc_take_o, .exc_num_o, .vec_addr_o, .sp_load_o,
      .stack_push_o, .stack_pop_o, .tail_chain_o);

   nvc_core_model core (.clk_i, .rst_b_i, .exc_take_i(exc_take_o), .tail_chain_i(tail_chain_o),
      .exc_num_i(exc_num_o), .delay_i(delay), .exc_ret_o(exc_ret_i), .handler_o(handler),
      .idle_o(idle));

   // ==========================================================
   // Output monitor and timeout
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         summarize();
      end
      if (stack_push_o) push_cyc = cyc;
      if (stack_pop_o) n_pop++;
      if (sp_load_o) begin
         sp_cyc = cyc;
         sp_vec = vec_addr_o;
      end
      if (exc_take_o) begin
         took     = 1'b1;
         take_num = exc_num_o;
         take_vec = vec_addr_o;
         take_tc  = tail_chain_o;
         take_cyc = cyc;
      end
   end

   // ==========================================================
   // Helpers
   function automatic logic [5:0] exp_exc(input int s);
      case (s)
         3: return 6'h04;
         4: return 6'h05;
         5: return 6'h06;
         6: return 6'h0b;
         7: return 6'h0c;
         default: return 6'h0f;
      endcase
   endfunction

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      addr_i  <= a;
      wdata_i <= d;
      wr_i    <= 1'b1;
      @(posedge clk_i);
      wr_i    <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk_i);
      addr_i <= a;
      rd_i   <= 1'b1;
      @(posedge clk_i);
      rd_i   <= 1'b0;
      #1 `CHK(rdata_o, e)
   endtask

   task automatic fire(input int s, input int i);
      @(posedge clk_i);
      case (s)
         0: fixed_irq_i[i] <= 1'b1;
         1: dma_irq_i[i] <= 1'b1;
         2: udb_sig_i[i] <= 1'b1;
         3: mem_fault_i <= 1'b1;
         4: bus_fault_i <= 1'b1;
         5: usage_fault_i <= 1'b1;
         6: svc_i <= 1'b1;
         7: dbg_mon_i <= 1'b1;
         8: system_tick_exception_i <= 1'b1;
         default: fixed_irq_i <= i;
      endcase
      @(posedge clk_i);
      fixed_irq_i <= '0;
      dma_irq_i   <= '0;
      udb_sig_i   <= '0;
      {mem_fault_i, bus_fault_i, usage_fault_i, svc_i, dbg_mon_i, system_tick_exception_i} <= '0;
   endtask

   task automatic take(input logic [5:0] e, input logic t);
      int n;
      n    = 0;
      took = 1'b0;
      while (!took && n < 400) begin
         @(posedge clk_i);
         #1 n++;
      end
      `CHK(took, 1'b1)
      `CHK(handler[0], 1'b1)
      `CHK(take_num, e)
      `CHK(take_vec, {2'b00, e, 2'b00})
      `CHK(take_tc, t)
      if (!t && e != 6'h01) `CHK(take_cyc - push_cyc, 9)
   endtask

   task automatic settle();
      int n;
      n = 0;
      while (!idle && n < 600) begin
         @(posedge clk_i);
         n++;
      end
      `CHK(idle, 1'b1)
      repeat (12) @(posedge clk_i);
   endtask

   task summarize();
      $display("Checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   // ==========================================================
   // Main sequence
   initial begin
      {rst_b_i, wr_i, rd_i, addr_i, wdata_i, fixed_irq_i, dma_irq_i, udb_sig_i, pins_i} = '0;
      {mem_fault_i, bus_fault_i, usage_fault_i, svc_i, dbg_mon_i, system_tick_exception_i} = '0;
      delay = 8'h03;
      k = $urandom(56);
      repeat (20) @(posedge clk_i);
      rst_b_i <= 1'b1;
      take(6'h01, 1'b0);
      `CHK(take_cyc - sp_cyc, 1)
      `CHK(sp_vec, 10'h000)
      rd(8'h00, 32'h0);
      rd(8'h40, 32'h0);
      rd(8'h20, 32'h0);
      rd(8'h80, 32'h0);
      wr(8'h10, 32'h07070707);
      rd(8'h10, 32'h0);
      wr(8'h14, 32'h07070707);
      rd(8'h14, 32'h00070707);
      wr(8'h1c, 32'h07070707);
      rd(8'h1c, 32'h07070007);
      wr(8'h00, 32'hffffffff);
      wr(8'h40, 32'h00000038);
      for (k = 3; k < 9; k++) begin
         fire(k, 0);
         take(exp_exc(k), 1'b0);
         settle();
      end
      wr(8'h40, 32'h00000040);
      take(6'h0e, 1'b0);
      settle();
      for (k = 3; k < 6; k++) begin
         fire(k, 0);
         take(6'h03, 1'b0);
         settle();
      end
      for (k = 0; k < 6; k++) begin
         j = $urandom % 32;
         fire(0, j);
         take(6'(16 + j), 1'b0);
         settle();
      end
      fire(9, 32'h60);
      take(6'h15, 1'b0);
      take(6'h16, 1'b1);
      settle();
      delay = 8'h28;
      for (k = 0; k < 2; k++) begin
         wr(8'h20, (k == 0) ? 32'h02000000 : 32'h01000000);
         wr(8'h28, (k == 0) ? 32'h00000100 : 32'h00000200);
         fire(9, 32'h208);
         take((k == 0) ? 6'h19 : 6'h13, 1'b0);
         take((k == 0) ? 6'h13 : 6'h19, 1'b1);
         settle();
      end
      fire(0, 9);
      repeat (2) @(posedge clk_i);
      fire(0, 3);
      take(6'h13, 1'b0);
      take(6'h19, 1'b1);
      settle();
      for (k = 1; k < 3; k++) begin
         j = $urandom % ((k == 1) ? 48 : 64);
         wr(8'h48, (j << 16) | (k << 8) | 20);
         fire(k, j);
         take(6'h24, 1'b0);
         settle();
      end
      j = $urandom % 64;
      wr(8'h40, 32'h80 | (j << 8));
      @(posedge clk_i);
      pins_i[j] <= 1'b1;
      take(6'h02, 1'b0);
      settle();
      `CHK(n_pop > 0, 1'b1)
      summarize();
   end
endmodule
